// ===== hdl/drc_pkg.sv
// Constants and carrier types for the compressor and event-interrupt block
package drc_pkg;

    // Register offsets
    localparam logic [6:0] ADDR_LATCHED = 7'h2C;
    localparam logic [6:0] ADDR_LIVE = 7'h2E;
    localparam logic [6:0] ADDR_INT_A = 7'h30;
    localparam logic [6:0] ADDR_INT_B = 7'h31;
    localparam logic [6:0] ADDR_PIN_ONE = 7'h33;
    localparam logic [6:0] ADDR_PIN_TWO = 7'h34;
    localparam logic [6:0] ADDR_PIN_AUDIO = 7'h35;
    localparam logic [6:0] ADDR_PIN_MISO = 7'h37;
    localparam logic [6:0] ADDR_THR = 7'h44;
    localparam logic [6:0] ADDR_HOLD = 7'h45;
    localparam logic [6:0] ADDR_RATE = 7'h46;

    // Reset value of every writable register
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field positions
    localparam int EN_LEFT_BIT = 6;
    localparam int EN_RIGHT_BIT = 5;
    localparam int THR_LSB = 2;
    localparam int HYST_LSB = 0;
    localparam int HOLD_LSB = 3;
    localparam int ATTACK_LSB = 4;
    localparam int DECAY_LSB = 0;
    localparam int INT_MODE_BIT = 0;
    localparam int INT_EVENT_LSB = 1;

    // Latched / live flag positions
    localparam int FLAG_OVERCURRENT = 7;
    localparam int FLAG_OVERFLOW = 6;
    localparam int FLAG_BUTTON = 5;
    localparam int FLAG_HEADSET = 4;
    localparam int FLAG_DRC_LEFT = 3;
    localparam int FLAG_DRC_RIGHT = 2;
    localparam int FLAG_AGC = 1;
    localparam int FLAG_DATA = 0;

    // Pin route select codes
    localparam logic [1:0] ROUTE_LINE_A = 2'h1;
    localparam logic [1:0] ROUTE_LINE_B = 2'h2;

    // Threshold and level arithmetic, in whole dB below full scale
    localparam logic [4:0] THR_TOP_DB = 5'h03;
    localparam logic [4:0] THR_STEP_DB = 5'h03;
    localparam logic [4:0] LEVEL_MAX_DB = 5'h1B;
    localparam int GAIN_FRAC_BITS = 24;

    // Attenuation accumulator in units of 2^-24 dB
    localparam logic [31:0] ATTN_MAX = 32'h1B00_0000;
    localparam logic [31:0] ATTACK_MAX_STEP = 32'h0400_0000;
    localparam logic [31:0] ATTACK_MIN_STEP = 32'h0000_00CD;
    localparam logic [31:0] DECAY_MAX_STEP = 32'h0000_6666;
    localparam logic [31:0] DECAY_MIN_STEP = 32'h0000_0008;
    localparam int HOLD_CNT_W = 16;

    // Linear magnitude of 0 dB .. -27 dB full scale, index = dB of attenuation
    localparam logic [27:0][15:0] LEVEL_TABLE = {
        16'h05B8, 16'h066A, 16'h0733, 16'h0814, 16'h0910, 16'h0A2B, 16'h0B69,
        16'h0CCD, 16'h0E5D, 16'h101D, 16'h1215, 16'h1449, 16'h16C3, 16'h198A,
        16'h1CA8, 16'h2027, 16'h2413, 16'h287A, 16'h2D6B, 16'h32F5, 16'h392D,
        16'h4027, 16'h47FB, 16'h50C3, 16'h5A9E, 16'h65AD, 16'h7215, 16'h7FFF};

    // Interrupt pulse timing
    localparam int CLK_MHZ = 40;
    localparam int INT_PULSE_NS = 1000;
    localparam int INT_PERIOD_NS = 8000;
    localparam logic [8:0] INT_PULSE_CYC = 9'((INT_PULSE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [8:0] INT_PERIOD_CYC = 9'((INT_PERIOD_NS * CLK_MHZ) / 1000);

    typedef struct packed {
        logic signed [15:0] left;
        logic signed [15:0] right;
    } sample_pair_type;

    typedef struct packed {
        logic headset_change;
        logic button_press;
        logic agc_noise;
        logic overcurrent;
        logic overflow;
        logic data_ready;
        logic touch;
    } event_in_type;

endpackage

// ===== hdl/drc_gain_and_event_interrupts.sv
// Playback compressor with event flags, two interrupt lines and its sample FIFO
`timescale 1ns/1ps

module sample_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
        logic ready;
    } fifo_state_type;

    fifo_state_type st_r;
    fifo_state_type st_nxt;
    logic push;
    logic pop;

    assign in_ready = st_r.ready;
    assign out_valid = st_r.count != '0;
    assign out_data = st_r.mem[st_r.rptr];

    always_comb begin
        st_nxt = st_r;
        push = in_valid && st_r.ready;
        pop = out_ready && (st_r.count != '0);
        if (push) begin
            st_nxt.mem[st_r.wptr] = in_data;
            st_nxt.wptr = st_r.wptr + 1'b1;
        end
        if (pop) begin
            st_nxt.rptr = st_r.rptr + 1'b1;
        end
        if (push && !pop) begin
            st_nxt.count = st_r.count + 1'b1;
        end else if (pop && !push) begin
            st_nxt.count = st_r.count - 1'b1;
        end
        // Ready is registered so the source sees a flop, never a comparator
        st_nxt.ready = st_nxt.count != (AW + 1)'(DEPTH);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.ready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

module drc_gain_and_event_interrupts #(
    parameter int FIFO_DEPTH = 4,
    parameter int HOLD_UNIT = 32
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire drc_pkg::sample_pair_type sample_in,
    input wire logic sample_in_valid,
    output logic sample_in_ready,
    output drc_pkg::sample_pair_type sample_out,
    output logic sample_out_valid,
    input wire logic sample_out_ready,
    input wire drc_pkg::event_in_type events,
    input wire logic headset_present,
    input wire logic button_held,
    output logic interrupt_line_a,
    output logic interrupt_line_b,
    output logic general_io_pin_one_out,
    output logic general_io_pin_one_oe,
    output logic general_io_pin_two_out,
    output logic general_io_pin_two_oe,
    output logic serial_audio_out_pin_out,
    output logic serial_audio_out_pin_oe,
    output logic spi_miso_pin_out,
    output logic spi_miso_pin_oe
);
    typedef struct packed {
        logic [7:0] thr_ctrl;
        logic [7:0] hold_ctrl;
        logic [7:0] rate_ctrl;
        logic [1:0][7:0] int_cfg;
        logic [3:0][1:0] pin_sel;
        logic [7:0] latched;
        logic [1:0] live_drc;
        logic [1:0] active;
        logic [1:0][31:0] attn;
        logic [1:0][drc_pkg::HOLD_CNT_W-1:0] hold_cnt;
        logic [7:0] rdata;
        drc_pkg::sample_pair_type out;
        logic out_valid;
        logic [1:0] train;
        logic [1:0][8:0] pcnt;
        logic [1:0] int_line;
        logic [3:0] pin_level;
        logic [3:0] pin_oe;
    } state_type;

    state_type st_r;
    state_type st_nxt;
    logic [1:0] rst_pipe_r;
    logic sys_rst_b;
    drc_pkg::sample_pair_type fifo_data;
    logic fifo_valid;
    logic pop;

    // Reset is asserted at once and released two edges later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe_r <= 2'b00;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign sys_rst_b = rst_pipe_r[1];

    // Holds samples while the downstream consumer stalls
    sample_fifo #(
        .WIDTH($bits(drc_pkg::sample_pair_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(sys_rst_b),
        .in_data(sample_in),
        .in_valid(sample_in_valid),
        .in_ready(sample_in_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(pop)
    );

    assign pop = fifo_valid && (!st_r.out_valid || sample_out_ready);

    always_comb begin
        logic signed [15:0] x;
        logic [15:0] mag;
        logic [4:0] thr_db;
        logic [4:0] on_db;
        logic [4:0] off_db;
        logic [1:0] hyst;
        logic [3:0] code;
        logic [31:0] att_step;
        logic [31:0] dec_step;
        logic [32:0] sum;
        logic [7:0] attn_db;
        logic [15:0] gain;
        logic signed [32:0] prod;
        logic [1:0] over;
        logic rd_latched;
        logic [7:0] set_bits;
        logic [6:0] ev7;
        logic trig;
        logic [7:0] cfg;
        x = '0;
        mag = '0;
        prod = '0;
        gain = '0;
        sum = '0;
        attn_db = '0;
        over = 2'b00;
        trig = 1'b0;
        cfg = '0;
        st_nxt = st_r;

        thr_db = 5'(drc_pkg::THR_TOP_DB + drc_pkg::THR_STEP_DB * 5'(st_r.thr_ctrl[drc_pkg::THR_LSB +: 3]));
        hyst = st_r.thr_ctrl[drc_pkg::HYST_LSB +: 2];
        // Less attenuation means a louder level, so activation sits hyst dB nearer full scale
        on_db = thr_db - 5'(hyst);
        off_db = thr_db + 5'(hyst);
        code = st_r.rate_ctrl[drc_pkg::ATTACK_LSB +: 4];
        att_step = (code == 4'hF) ? drc_pkg::ATTACK_MIN_STEP : (drc_pkg::ATTACK_MAX_STEP >> code);
        code = st_r.rate_ctrl[drc_pkg::DECAY_LSB +: 4];
        dec_step = (code == 4'hF) ? drc_pkg::DECAY_MIN_STEP : (drc_pkg::DECAY_MAX_STEP >> code);

        if (sample_out_ready) begin
            st_nxt.out_valid = 1'b0;
        end

        if (pop) begin
            for (int ch = 0; ch < 2; ch++) begin
                x = (ch == 0) ? fifo_data.left : fifo_data.right;
                mag = x[15] ? 16'(-x) : x;
                over[ch] = mag > drc_pkg::LEVEL_TABLE[thr_db];
                st_nxt.live_drc[ch] = over[ch];

                // Gain reduction in force for this sample, whole dB resolution
                attn_db = st_r.attn[ch][31:drc_pkg::GAIN_FRAC_BITS];
                if (attn_db > 8'(drc_pkg::LEVEL_MAX_DB)) begin
                    attn_db = 8'(drc_pkg::LEVEL_MAX_DB);
                end
                gain = drc_pkg::LEVEL_TABLE[attn_db[4:0]];
                prod = x * $signed({1'b0, gain});
                if (attn_db == 8'h00 || !st_r.thr_ctrl[(ch == 0) ? drc_pkg::EN_LEFT_BIT : drc_pkg::EN_RIGHT_BIT]) begin
                    prod = 33'(x) <<< 15;
                end
                if (ch == 0) begin
                    st_nxt.out.left = prod[30:15];
                end else begin
                    st_nxt.out.right = prod[30:15];
                end

                if (!st_r.thr_ctrl[(ch == 0) ? drc_pkg::EN_LEFT_BIT : drc_pkg::EN_RIGHT_BIT]) begin
                    st_nxt.active[ch] = 1'b0;
                    st_nxt.attn[ch] = '0;
                    st_nxt.hold_cnt[ch] = '0;
                end else begin
                    if (!st_r.active[ch]) begin
                        st_nxt.active[ch] = mag > drc_pkg::LEVEL_TABLE[on_db];
                    end else if (mag < drc_pkg::LEVEL_TABLE[off_db]) begin
                        st_nxt.active[ch] = 1'b0;
                    end
                    if (st_nxt.active[ch] && over[ch]) begin
                        sum = {1'b0, st_r.attn[ch]} + {1'b0, att_step};
                        st_nxt.attn[ch] = (sum > {1'b0, drc_pkg::ATTN_MAX}) ? drc_pkg::ATTN_MAX : sum[31:0];
                        st_nxt.hold_cnt[ch] = drc_pkg::HOLD_CNT_W'(
                            st_r.hold_ctrl[drc_pkg::HOLD_LSB +: 4] * HOLD_UNIT);
                    end else if (st_r.hold_cnt[ch] != '0) begin
                        st_nxt.hold_cnt[ch] = st_r.hold_cnt[ch] - 1'b1;
                    end else if (st_r.attn[ch] > dec_step) begin
                        st_nxt.attn[ch] = st_r.attn[ch] - dec_step;
                    end else begin
                        st_nxt.attn[ch] = '0;
                    end
                end
            end
            st_nxt.out_valid = 1'b1;
        end

        // Flag sources for this cycle
        set_bits = 8'h00;
        set_bits[drc_pkg::FLAG_OVERCURRENT] = events.overcurrent;
        set_bits[drc_pkg::FLAG_OVERFLOW] = events.overflow;
        set_bits[drc_pkg::FLAG_BUTTON] = events.button_press;
        set_bits[drc_pkg::FLAG_HEADSET] = events.headset_change;
        set_bits[drc_pkg::FLAG_DRC_LEFT] = over[0];
        set_bits[drc_pkg::FLAG_DRC_RIGHT] = over[1];
        set_bits[drc_pkg::FLAG_AGC] = events.agc_noise;
        set_bits[drc_pkg::FLAG_DATA] = events.data_ready | events.touch;

        ev7 = {events.headset_change, events.button_press, |over, events.agc_noise,
               events.overcurrent, events.overflow, events.data_ready | events.touch};

        // Register port
        rd_latched = reg_rd_en && (reg_addr == drc_pkg::ADDR_LATCHED);
        if (reg_rd_en) begin
            unique case (reg_addr)
                drc_pkg::ADDR_LATCHED: st_nxt.rdata = st_r.latched;
                drc_pkg::ADDR_LIVE: st_nxt.rdata = {2'b00, button_held, headset_present,
                                                    st_r.live_drc[0], st_r.live_drc[1], 2'b00};
                drc_pkg::ADDR_INT_A: st_nxt.rdata = st_r.int_cfg[0];
                drc_pkg::ADDR_INT_B: st_nxt.rdata = st_r.int_cfg[1];
                drc_pkg::ADDR_PIN_ONE: st_nxt.rdata = {6'h00, st_r.pin_sel[0]};
                drc_pkg::ADDR_PIN_TWO: st_nxt.rdata = {6'h00, st_r.pin_sel[1]};
                drc_pkg::ADDR_PIN_AUDIO: st_nxt.rdata = {6'h00, st_r.pin_sel[2]};
                drc_pkg::ADDR_PIN_MISO: st_nxt.rdata = {6'h00, st_r.pin_sel[3]};
                drc_pkg::ADDR_THR: st_nxt.rdata = st_r.thr_ctrl;
                drc_pkg::ADDR_HOLD: st_nxt.rdata = st_r.hold_ctrl;
                drc_pkg::ADDR_RATE: st_nxt.rdata = st_r.rate_ctrl;
                default: st_nxt.rdata = 8'h00;
            endcase
        end
        if (reg_wr_en) begin
            unique case (reg_addr)
                drc_pkg::ADDR_INT_A: st_nxt.int_cfg[0] = reg_wdata;
                drc_pkg::ADDR_INT_B: st_nxt.int_cfg[1] = reg_wdata;
                drc_pkg::ADDR_PIN_ONE: st_nxt.pin_sel[0] = reg_wdata[1:0];
                drc_pkg::ADDR_PIN_TWO: st_nxt.pin_sel[1] = reg_wdata[1:0];
                drc_pkg::ADDR_PIN_AUDIO: st_nxt.pin_sel[2] = reg_wdata[1:0];
                drc_pkg::ADDR_PIN_MISO: st_nxt.pin_sel[3] = reg_wdata[1:0];
                drc_pkg::ADDR_THR: st_nxt.thr_ctrl = reg_wdata;
                drc_pkg::ADDR_HOLD: st_nxt.hold_ctrl = reg_wdata;
                drc_pkg::ADDR_RATE: st_nxt.rate_ctrl = reg_wdata;
                default: st_nxt.thr_ctrl = st_r.thr_ctrl;
            endcase
        end

        // Clear on read, then new events on top so none is lost
        if (rd_latched) begin
            st_nxt.latched = 8'h00;
        end
        st_nxt.latched = st_nxt.latched | set_bits;

        for (int i = 0; i < 2; i++) begin
            cfg = st_r.int_cfg[i];
            trig = |(cfg[7:drc_pkg::INT_EVENT_LSB] & ev7);
            if (cfg[drc_pkg::INT_MODE_BIT]) begin
                if (rd_latched) begin
                    st_nxt.train[i] = 1'b0;
                end
                if (trig) begin
                    st_nxt.train[i] = 1'b1;
                end
                if (trig && !st_r.train[i]) begin
                    st_nxt.pcnt[i] = '0;
                end else if (st_nxt.train[i]) begin
                    st_nxt.pcnt[i] = (st_r.pcnt[i] == drc_pkg::INT_PERIOD_CYC - 9'h001) ? 9'h000
                                     : st_r.pcnt[i] + 9'h001;
                end else begin
                    st_nxt.pcnt[i] = '0;
                end
                st_nxt.int_line[i] = st_nxt.train[i] && (st_nxt.pcnt[i] < drc_pkg::INT_PULSE_CYC);
            end else begin
                st_nxt.train[i] = 1'b0;
                if (trig) begin
                    st_nxt.pcnt[i] = drc_pkg::INT_PULSE_CYC;
                end else if (st_r.pcnt[i] != '0) begin
                    st_nxt.pcnt[i] = st_r.pcnt[i] - 9'h001;
                end
                st_nxt.int_line[i] = st_nxt.pcnt[i] != '0;
            end
        end

        // Pin routing; an unselected pin is left undriven
        for (int p = 0; p < 4; p++) begin
            st_nxt.pin_oe[p] = (st_r.pin_sel[p] == drc_pkg::ROUTE_LINE_A) ||
                               (st_r.pin_sel[p] == drc_pkg::ROUTE_LINE_B);
            st_nxt.pin_level[p] = (st_r.pin_sel[p] == drc_pkg::ROUTE_LINE_A) ? st_nxt.int_line[0]
                                : (st_r.pin_sel[p] == drc_pkg::ROUTE_LINE_B) ? st_nxt.int_line[1]
                                : 1'b0;
        end
    end

    always_ff @(posedge clk or negedge sys_rst_b) begin
        if (!sys_rst_b) begin
            st_r <= '0;
            st_r.thr_ctrl <= drc_pkg::REG_RESET;
            st_r.hold_ctrl <= drc_pkg::REG_RESET;
            st_r.rate_ctrl <= drc_pkg::REG_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign sample_out = st_r.out;
    assign sample_out_valid = st_r.out_valid;
    assign interrupt_line_a = st_r.int_line[0];
    assign interrupt_line_b = st_r.int_line[1];
    assign general_io_pin_one_out = st_r.pin_level[0];
    assign general_io_pin_one_oe = st_r.pin_oe[0];
    assign general_io_pin_two_out = st_r.pin_level[1];
    assign general_io_pin_two_oe = st_r.pin_oe[1];
    assign serial_audio_out_pin_out = st_r.pin_level[2];
    assign serial_audio_out_pin_oe = st_r.pin_oe[2];
    assign spi_miso_pin_out = st_r.pin_level[3];
    assign spi_miso_pin_oe = st_r.pin_oe[3];
endmodule

// ===== tb/drc_asserts.sv
// Port-level assertions for the compressor and event-interrupt block
`timescale 1ns/1ps
module drc_asserts #(
    parameter int FIFO_DEPTH = 4,
    parameter int HOLD_UNIT = 32
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [6:0] reg_addr,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rdata,
    input wire logic sample_in_valid,
    input wire logic sample_in_ready,
    input wire drc_pkg::sample_pair_type sample_out,
    input wire logic sample_out_valid,
    input wire logic sample_out_ready,
    input wire drc_pkg::event_in_type events,
    input wire logic headset_present,
    input wire logic interrupt_line_a,
    input wire logic interrupt_line_b,
    input wire logic general_io_pin_one_out,
    input wire logic general_io_pin_one_oe,
    input wire logic spi_miso_pin_out,
    input wire logic spi_miso_pin_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Reads well after reset, once the internal reset copy has let go
    sequence lat_rd;
        reg_rd_en && reg_addr == drc_pkg::ADDR_LATCHED && events == '0 && $past(rst_b, 3);
    endsequence
    sequence live_rd;
        reg_rd_en && reg_addr == drc_pkg::ADDR_LIVE && $past(rst_b, 3);
    endsequence
    latched_clear_a: assert property (lat_rd ##1 events == '0 ##1 lat_rd |=> (reg_rdata & 8'hF3) == 8'h00)
        else $error("latched flag kept after read");
    live_state_a: assert property ((live_rd and $stable(headset_present)) |=> reg_rdata[4] == $past(headset_present))
        else $error("live headset bit wrong");
    unmapped_zero_a: assert property (reg_rd_en && reg_addr == 7'h01 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    out_hold_a: assert property (sample_out_valid && !sample_out_ready |=> sample_out_valid && $stable(sample_out))
        else $error("stalled sample dropped or changed");
    in_ready_a: assert property ($fell(sample_in_ready) |-> $past(sample_in_valid))
        else $error("input refused without a push");
    pin_one_a: assert property (general_io_pin_one_oe |-> general_io_pin_one_out == interrupt_line_a)
        else $error("pin one does not follow its line");
    miso_pin_a: assert property (spi_miso_pin_oe |-> spi_miso_pin_out == interrupt_line_b)
        else $error("miso pin does not follow its line");
endmodule

bind drc_gain_and_event_interrupts drc_asserts #(.FIFO_DEPTH(FIFO_DEPTH), .HOLD_UNIT(HOLD_UNIT)) u_asserts (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .sample_in_valid(sample_in_valid), .sample_in_ready(sample_in_ready), .sample_out(sample_out),
    .sample_out_valid(sample_out_valid), .sample_out_ready(sample_out_ready), .events(events),
    .headset_present(headset_present), .interrupt_line_a(interrupt_line_a), .interrupt_line_b(interrupt_line_b),
    .general_io_pin_one_out(general_io_pin_one_out), .general_io_pin_one_oe(general_io_pin_one_oe),
    .spi_miso_pin_out(spi_miso_pin_out), .spi_miso_pin_oe(spi_miso_pin_oe));

// ===== tb/host_sink.sv
// Downstream sample sink: accepts at random, or stalls on request
`timescale 1ns/1ps
module host_sink (
    input wire logic clk,
    input wire logic stall,
    output logic sample_out_ready
);
    initial sample_out_ready = 1'b0;
    // Random gaps exercise the output hold path even without a stall
    always @(posedge clk) sample_out_ready <= !stall && ($urandom_range(3) != 0);
endmodule

// ===== tb/drc_gain_and_event_interrupts_test.sv
// Self-checking bench: registers, events, interrupts and the sample path
`timescale 1ns/1ps
module drc_gain_and_event_interrupts_test;
    localparam int LB[7] = '{0, 0, 6, 7, 1, 5, 4};
    localparam int CB[7] = '{1, 1, 2, 3, 4, 6, 7};
    localparam logic [6:0] RG[9] = '{7'h30, 7'h31, 7'h33, 7'h34, 7'h35, 7'h37, 7'h44, 7'h45, 7'h46};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    drc_pkg::sample_pair_type sample_in = '0;
    drc_pkg::sample_pair_type sample_out;
    logic sample_in_valid = 1'b0;
    logic sample_in_ready, sample_out_valid, sample_out_ready;
    drc_pkg::event_in_type events = '0;
    logic headset_present = 1'b0;
    logic button_held = 1'b0;
    logic stall = 1'b0;
    logic la, lb, p1o, p1e, mo, me;
    int failures = 0;
    int n_compared = 0;
    drc_pkg::sample_pair_type sent_q[$], got_q[$];
    drc_gain_and_event_interrupts #(.FIFO_DEPTH(4), .HOLD_UNIT(2)) u_dut (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_in(sample_in), .sample_in_valid(sample_in_valid),
        .sample_in_ready(sample_in_ready), .sample_out(sample_out), .sample_out_valid(sample_out_valid),
        .sample_out_ready(sample_out_ready), .events(events), .headset_present(headset_present),
        .button_held(button_held), .interrupt_line_a(la), .interrupt_line_b(lb), .general_io_pin_one_out(p1o),
        .general_io_pin_one_oe(p1e), .general_io_pin_two_out(), .general_io_pin_two_oe(),
        .serial_audio_out_pin_out(), .serial_audio_out_pin_oe(), .spi_miso_pin_out(mo), .spi_miso_pin_oe(me));
    host_sink u_sink (.clk(clk), .stall(stall), .sample_out_ready(sample_out_ready));
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (sample_out_valid && sample_out_ready) got_q.push_back(sample_out);
    task automatic final_report();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic hang();
        failures++;
        final_report();
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_smp(input drc_pkg::sample_pair_type got, input drc_pkg::sample_pair_type exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd_en <= 1'b1;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk_reg(d, e);
    endtask
    task automatic ev(input int i);
        @(posedge clk);
        events <= 7'(1 << i);
        @(posedge clk);
        events <= '0;
    endtask
    function automatic logic lv(input bit b);
        return b ? lb : la;
    endfunction
    // Cycles the line stays high, after waiting up to w cycles for it to rise
    task automatic plen(input bit b, input int w, output int n);
        int k;
        n = 0;
        for (k = 0; k < w && lv(b) !== 1'b1; k++) @(posedge clk);
        while (lv(b) === 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic push(input drc_pkg::sample_pair_type s);
        int k;
        @(posedge clk);
        sample_in <= s;
        sample_in_valid <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge clk);
            if (sample_in_ready === 1'b1) break;
        end
        sample_in_valid <= 1'b0;
        sent_q.push_back(s);
        if (k == 64) hang();
    endtask
    task automatic settle();
        int k;
        for (k = 0; k < 300 && got_q.size() < sent_q.size(); k++) @(posedge clk);
        if (k == 300) hang();
    endtask
    task automatic drain();
        settle();
        while (sent_q.size() > 0) chk_smp(got_q.pop_front(), sent_q.pop_front());
        got_q.delete();
    endtask
    initial begin
        logic [7:0] d;
        logic signed [15:0] v;
        int n, i;
        void'($urandom(32'h293BC28C));
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (RG[j]) rdc(RG[j], drc_pkg::REG_RESET);
        rdc(7'h2C, 8'h00);
        foreach (RG[j]) begin
            d = 8'($urandom);
            wr(RG[j], d);
            rdc(RG[j], (j > 1 && j < 6) ? d & 8'h03 : d);
            wr(RG[j], 8'h00);
        end
        wr(7'h01, 8'hFF);
        rdc(7'h01, 8'h00);
        wr(7'h33, {6'h00, drc_pkg::ROUTE_LINE_A});
        wr(7'h37, {6'h00, drc_pkg::ROUTE_LINE_B});
        for (i = 0; i < 7; i++) begin
            wr(7'h30, 8'(1 << CB[i]));
            ev(i);
            plen(1'b0, 4, n);
            chk_reg(8'(n), 8'(drc_pkg::INT_PULSE_CYC));
            chk_reg({lb, p1e, 6'h00}, 8'h40);
            rdc(7'h2C, 8'(1 << LB[i]));
            rdc(7'h2C, 8'h00);
        end
        fork
            rd(7'h2C, d);
            ev(5);
        join
        rdc(7'h2C, 8'h20);
        wr(7'h31, 8'h41);
        ev(5);
        plen(1'b1, 4, n);
        chk_reg(8'(n), 8'(drc_pkg::INT_PULSE_CYC));
        plen(1'b1, 320, n);
        chk_reg(8'(n), 8'(drc_pkg::INT_PULSE_CYC));
        rdc(7'h2C, 8'h20);
        plen(1'b1, 340, n);
        chk_reg(8'(n), 8'h00);
        wr(7'h31, 8'h00);
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            v = drc_pkg::LEVEL_TABLE[3 + 3 * i];
            headset_present <= i[0];
            button_held <= i[1];
            wr(7'h44, 8'(i << 2));
            push({v + 16'sh0001, v});
            push({-v, -v - 16'sh0001});
            settle();
            rdc(7'h2C, 8'h0C);
            rdc(7'h2E, {2'h0, i[1], i[0], 4'h4});
        end
        drain();
        wr(7'h46, 8'h00);
        wr(7'h44, 8'h7F);
        for (i = 0; i < 3; i++) push(32'h4000_4000);
        settle();
        chk_smp(got_q[2], {2{drc_pkg::LEVEL_TABLE[8] >> 1}});
        sent_q.delete();
        got_q.delete();
        wr(7'h44, 8'h1C);
        push(32'h4000_4000);
        drain();
        // Stall the sink so the FIFO fills and refuses, then drain in order
        stall <= 1'b1;
        n = 0;
        sample_in <= $urandom;
        sample_in_valid <= 1'b1;
        for (i = 0; i < 12; i++) begin
            @(posedge clk);
            if (sample_in_ready === 1'b1) begin
                sent_q.push_back(sample_in);
                sample_in <= $urandom;
                n++;
            end
        end
        sample_in_valid <= 1'b0;
        chk_reg({sample_in_ready, 6'h00, n >= 4}, 8'h01);
        stall <= 1'b0;
        drain();
        final_report();
    end
endmodule
